/* shw_pkg.sv */
/*
  Constants, field layout, reset values and state type shared by the
  reset, sleep and watchdog controller.
  Assumes a 25 MHz core clock; the cycle counts given in ms are derived from it.
*/
package shw_pkg;

  // Clock rate in kHz, so that a time in ms times this is a cycle count
  localparam int CLK_KHZ = 25000;

  // Expanded bank F register offsets
  localparam logic [3:0] ADDR_STOP_RECOVERY = 4'hB;
  localparam logic [3:0] ADDR_WATCHDOG_MODE = 4'hF;

  // stop_recovery_config fields
  localparam int SMR_DIV16 = 0;
  localparam int SMR_SRC_LO = 2;
  localparam int SMR_DELAY = 5;
  localparam int SMR_LEVEL = 6;
  localparam int SMR_WARM = 7;
  localparam logic [7:0] SMR_RESET = 8'h20;

  // watchdog_mode_config fields
  localparam int WDM_TSEL_LO = 0;
  localparam int WDM_HALT_RUN = 2;
  localparam int WDM_STOP_RUN = 3;
  localparam int WDM_XTAL_SEL = 4;
  localparam logic [4:0] WDM_RESET = 5'h0D;

  // Power-on-reset delay, least time
  localparam int POR_MIN_MS = 5;
  localparam int POR_CYCLES = POR_MIN_MS * CLK_KHZ;

  // Stop recovery delay when the crystal clocks the counter chain
  localparam int REC_XTAL_DIV = 256;

  // Watchdog timeouts, RC source (least times, ms) and crystal periods
  localparam int WDT_MS_0 = 10;
  localparam int WDT_MS_1 = 20;
  localparam int WDT_MS_2 = 40;
  localparam int WDT_MS_3 = 160;
  localparam int WDT_CYC_0 = WDT_MS_0 * CLK_KHZ;
  localparam int WDT_CYC_1 = WDT_MS_1 * CLK_KHZ;
  localparam int WDT_CYC_2 = WDT_MS_2 * CLK_KHZ;
  localparam int WDT_CYC_3 = WDT_MS_3 * CLK_KHZ;
  localparam int WDT_XT_0 = 512;
  localparam int WDT_XT_1 = 1024;
  localparam int WDT_XT_2 = 2048;
  localparam int WDT_XT_3 = 8192;

  // Watchdog mode register write window: processor cycles and clocks
  localparam int WIN_PROC_CYC = 64;
  localparam int CLK_PER_PROC = 2;
  localparam logic [7:0] WIN_CLKS = 8'(WIN_PROC_CYC * CLK_PER_PROC);

  // Restart address after stop recovery
  localparam logic [15:0] RESTART_PC = 16'h000C;

  // Divide-by-16 prescaler terminal value
  localparam logic [3:0] DIV16_LAST = 4'hF;

  // Value written to zero, sign and overflow by the watchdog instruction
  localparam logic [2:0] WDT_FLAG_ZSV = 3'h0;

  typedef enum logic [2:0] {
    ST_POR,
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_RECOVER
  } shw_state_t;

endpackage

/* shw_tick_timer.sv */
/*
  Counter with sticky expiry, shared by the reset delay and the watchdog.
  Assumes tick is a single-cycle strobe on the core clock.
*/
`timescale 1ns/10ps
module shw_tick_timer #(
  parameter int TW = 23
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic tick,
  input wire logic [TW-1:0] limit,
  // Status
  output logic expired
);

  initial
  begin
    if (TW < 2)
      $error("shw_tick_timer: TW must be at least 2");
  end

  logic [TW-1:0] cnt_ff;
  logic exp_ff;
  wire [TW-1:0] last = limit - TW'(1);
  wire step = run & tick & ~exp_ff;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff <= '0;
      exp_ff <= 1'b0;
    end
    else if (clear)
    begin
      cnt_ff <= '0;
      exp_ff <= 1'b0;
    end
    else if (step)
    begin
      cnt_ff <= cnt_ff + TW'(1);
      exp_ff <= (cnt_ff == last);
    end
  end

  assign expired = exp_ff;

endmodule

/* shw_wake_sel.sv */
/*
  Stop-mode wake source selection and level match.
  Assumes all port inputs are already synchronised to the core clock.
*/
`timescale 1ns/10ps
module shw_wake_sel (
  // Configuration
  input wire logic [2:0] src_sel,
  input wire logic wake_level,
  input wire logic port3_analog,
  // Port lines
  input wire logic port3_line1,
  input wire logic port3_line2,
  input wire logic port3_line3,
  input wire logic [7:0] port2_in,
  // Result
  output logic wake
);

  logic src_val;
  logic src_ok;

  always_comb
  begin
    src_val = 1'b0;
    src_ok = 1'b1;
    unique case (src_sel)
      3'h0, 3'h1: src_ok = 1'b0;                      // [RQ10]
      3'h2: src_val = port3_line1;
      3'h3: src_val = port3_line2;
      3'h4: src_val = port3_line3;
      3'h5: src_val = port2_in[7];
      3'h6: src_val = ~|port2_in[3:0];
      3'h7: src_val = ~|port2_in;
    endcase
    // Comparator inputs are analog and cannot wake
    if (port3_analog && (src_sel inside {3'h2, 3'h3, 3'h4}))
      src_ok = 1'b0;                                  // [RQ11]
  end

  assign wake = src_ok & (src_val == wake_level);    // [RQ13]

endmodule

/* shw_ctl.sv */
/*
  Reset, halt/stop and watchdog controller of a small 8-bit controller.
  Holds the stop recovery and watchdog mode registers in expanded bank F.
  Assumes the core decodes bank F selection, gives single-cycle pulses for
  the stop, halt and watchdog instructions, and that the interrupt logic
  raises irq_wake for an enabled request. Supply, crystal and port inputs
  are asynchronous.
*/
`timescale 1ns/10ps

// Behaviour
// [RQ1] Reset delay starts on four trigger sources
// [RQ2] Execution held at least 5 ms
// [RQ3] Halt gates cpu clock, interrupts wake it
// [RQ4] Recovery register at 0BH, bit 7 readable
// [RQ5] Warm flag set on stop, cleared on reset
// [RQ6] Crystal-clocked recovery lasts 256 crystal clocks
// [RQ7] Stop kills clocks, restarts at 000CH
// [RQ8] Software puts a no-op before sleeping
// [RQ9] Bit 0 divides system and timer clocks
// [RQ10] Bits 4..2 pick the wake source
// [RQ11] Analog port-3 lines cannot wake stop
// [RQ12] Bit 5 applies delay after recovery
// [RQ13] Bit 6 chooses wake level, resets low
// [RQ14] Watchdog is retriggered one-shot causing reset
// [RQ15] Watchdog instruction updates zero, sign, overflow
// [RQ16] Watchdog mode writable only first 64 cycles
// [RQ17] Watchdog mode write-only at 0FH, bits 7..5 reserved
// [RQ18] Bits 1..0 select watchdog period
// [RQ19] Watchdog reset defaults period to 20 ms
// [RQ20] Bits 2, 3 keep watchdog in halt, stop
// [RQ21] Bit 4 selects crystal or RC clock
// [RQ22] Low supply forces global reset
// [RQ23] Stop recovery keeps configuration registers
module shw_ctl
  import shw_pkg::*;
#(
  parameter int TW = 23,
  parameter int POR_CYC = POR_CYCLES,
  parameter int WDT_RC_0 = WDT_CYC_0,
  parameter int WDT_RC_1 = WDT_CYC_1,
  parameter int WDT_RC_2 = WDT_CYC_2,
  parameter int WDT_RC_3 = WDT_CYC_3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Expanded bank F register port
  input wire logic reg_bank_f,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Core instruction events and interrupt wake
  input wire logic insn_stop,
  input wire logic insn_halt,
  input wire logic insn_watchdog,
  input wire logic irq_wake,
  // Supply monitors and clock pin
  input wire logic power_good,
  input wire logic brownout_trip,
  input wire logic supply_low,
  input wire logic crystal_input_pin,
  // Wake inputs
  input wire logic port3_line1,
  input wire logic port3_line2,
  input wire logic port3_line3,
  input wire logic [7:0] port2_in,
  input wire logic port3_analog,
  // Core control
  output logic cpu_reset,
  output logic global_reset,
  output logic cpu_clk_en,
  output logic timer_interrupt_clk_en,
  output logic xtal_osc_en,
  output logic restart_req,
  output logic [15:0] restart_pc,
  output logic flag_we,
  output logic [2:0] flag_zsv
);

  initial
  begin
    if (POR_CYC < 2 || POR_CYC >= (1 << TW) || WDT_RC_3 >= (1 << TW) ||
        WDT_RC_0 < 2 || WDT_XT_3 >= (1 << TW))
      $error("shw_ctl: counts do not fit the timer width");
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  localparam int NSYNC = 15;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic pg_prev_ff;
  logic xt_prev_ff;

  wire [NSYNC-1:0] raw_in = {power_good, brownout_trip, supply_low,
                             crystal_input_pin, port3_line3, port3_line2,
                             port3_line1, port2_in};

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      pg_prev_ff <= 1'b0;
      xt_prev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      pg_prev_ff <= sync2_ff[14];
      xt_prev_ff <= sync2_ff[11];
    end
  end

  wire pg_s = sync2_ff[14];
  wire bo_s = sync2_ff[13];
  wire low_s = sync2_ff[12];
  wire xt_s = sync2_ff[11];
  wire [2:0] p3_s = sync2_ff[10:8];
  wire [7:0] p2_s = sync2_ff[7:0];
  wire xt_edge = xt_s & ~xt_prev_ff;

  ////////////////////////////////////////////////////////////////////////
  // Reset sources

  shw_state_t state_ff;
  shw_state_t nxt_state;
  logic [6:0] smr_ff;
  logic warm_ff;
  logic [4:0] wdm_ff;
  logic wdt_en_ff;
  logic wdt_exp;
  logic por_done;
  logic wake;

  wire low_supply = bo_s | low_s;                           // [RQ22]
  wire pwr_rise = pg_s & ~pg_prev_ff;
  // Any of these resets the state, both timers and the bank F registers and starts the delay
  wire soft_init = pwr_rise | low_supply | wdt_exp;         // [RQ1]

  wire xtal_sel = wdm_ff[WDM_XTAL_SEL];                     // [RQ21]
  wire rec_delay = smr_ff[SMR_DELAY];
  wire in_run = (state_ff == ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Sleep and reset state machine

  logic exec_start;
  logic restart;
  logic rec_start;

  always_comb
  begin
    nxt_state = state_ff;
    exec_start = 1'b0;
    restart = 1'b0;
    rec_start = 1'b0;
    if (soft_init)
      nxt_state = ST_POR;
    else
    begin
      unique case (state_ff)
        ST_POR:
          if (por_done)                                     // [RQ2]
          begin
            nxt_state = ST_RUN;
            exec_start = 1'b1;
          end
        ST_RUN:
          if (insn_stop)
            nxt_state = ST_STOP;
          else if (insn_halt)
            nxt_state = ST_HALT;
        ST_HALT:
          if (irq_wake)                                     // [RQ3]
            nxt_state = ST_RUN;
        ST_STOP:
          if (wake && rec_delay)                            // [RQ12]
          begin
            nxt_state = ST_RECOVER;
            rec_start = 1'b1;
          end
          else if (wake)
          begin
            nxt_state = ST_RUN;
            restart = 1'b1;                                 // [RQ7]
            exec_start = 1'b1;
          end
        ST_RECOVER:
          if (por_done)
          begin
            nxt_state = ST_RUN;
            restart = 1'b1;
            exec_start = 1'b1;
          end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state_ff <= ST_POR;
    else
      state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset delay timer

  // Crystal recovery counts crystal edges; otherwise core cycles
  wire rec_xtal = (state_ff == ST_RECOVER) & xtal_sel;
  wire por_tick = rec_xtal ? xt_edge : 1'b1;                // [RQ6]
  wire [TW-1:0] por_limit = rec_xtal ? TW'(REC_XTAL_DIV) : TW'(POR_CYC);
  wire por_run = (state_ff == ST_POR) | (state_ff == ST_RECOVER);

  shw_tick_timer #(.TW(TW)) u_por_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .clear(soft_init | rec_start),                          // [RQ1]
    .run(por_run),
    .tick(por_tick),
    .limit(por_limit),
    .expired(por_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Stop wake source

  shw_wake_sel u_wake_sel (
    .src_sel(smr_ff[SMR_SRC_LO+2:SMR_SRC_LO]),
    .wake_level(smr_ff[SMR_LEVEL]),
    .port3_analog(port3_analog),
    .port3_line1(p3_s[0]),
    .port3_line2(p3_s[1]),
    .port3_line3(p3_s[2]),
    .port2_in(p2_s),
    .wake(wake)
  );

  ////////////////////////////////////////////////////////////////////////
  // Watchdog

  wire wdt_kick = insn_watchdog & in_run;
  wire [1:0] tsel = wdm_ff[WDM_TSEL_LO+1:WDM_TSEL_LO];
  logic [TW-1:0] wdt_limit;

  always_comb
  begin
    unique case (tsel)                                      // [RQ18]
      2'h0: wdt_limit = xtal_sel ? TW'(WDT_XT_0) : TW'(WDT_RC_0);
      2'h1: wdt_limit = xtal_sel ? TW'(WDT_XT_1) : TW'(WDT_RC_1);
      2'h2: wdt_limit = xtal_sel ? TW'(WDT_XT_2) : TW'(WDT_RC_2);
      2'h3: wdt_limit = xtal_sel ? TW'(WDT_XT_3) : TW'(WDT_RC_3);
    endcase
  end

  // Crystal is off in stop, so only the RC source can count there
  wire wdt_active = wdt_en_ff & ((state_ff == ST_RUN) |
    (state_ff == ST_RECOVER) |
    ((state_ff == ST_HALT) & wdm_ff[WDM_HALT_RUN]) |
    ((state_ff == ST_STOP) & wdm_ff[WDM_STOP_RUN] & ~xtal_sel)); // [RQ20]
  wire wdt_tick = xtal_sel ? xt_edge : 1'b1;                // [RQ21]

  shw_tick_timer #(.TW(TW)) u_wdt_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .clear(soft_init | wdt_kick),                           // [RQ14]
    .run(wdt_active),
    .tick(wdt_tick),
    .limit(wdt_limit),
    .expired(wdt_exp)
  );

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      wdt_en_ff <= 1'b0;
    else if (soft_init)
      wdt_en_ff <= 1'b0;
    else if (wdt_kick)
      wdt_en_ff <= 1'b1;                                    // [RQ14]
  end

  ////////////////////////////////////////////////////////////////////////
  // Bank F registers

  logic [7:0] win_cnt_ff;
  logic [7:0] rdata_ff;
  wire win_open = (win_cnt_ff < WIN_CLKS);
  wire wr_smr = reg_bank_f & reg_wr & (reg_addr == ADDR_STOP_RECOVERY);
  wire wr_wdm = reg_bank_f & reg_wr & (reg_addr == ADDR_WATCHDOG_MODE);
  wire rd_smr = reg_bank_f & reg_rd & (reg_addr == ADDR_STOP_RECOVERY);
  wire stop_entry = in_run & insn_stop & ~soft_init;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      win_cnt_ff <= WIN_CLKS;
    else if (exec_start)
      win_cnt_ff <= 8'h00;
    else if (win_open && (in_run || state_ff == ST_HALT))
      win_cnt_ff <= win_cnt_ff + 8'h01;                     // [RQ16]
  end

  // Stop recovery does not pass through soft_init, so settings survive
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      smr_ff <= SMR_RESET[6:0];
    else if (soft_init)
      smr_ff <= SMR_RESET[6:0];                             // [RQ23]
    else if (wr_smr)
      smr_ff <= reg_wdata[6:0];                             // [RQ4]
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      warm_ff <= 1'b0;
    else if (stop_entry)
      warm_ff <= 1'b1;                                      // [RQ5]
    else if (soft_init)
      warm_ff <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      wdm_ff <= WDM_RESET;
    else if (soft_init)
      wdm_ff <= WDM_RESET;                                  // [RQ19]
    else if (wr_wdm && win_open)
      wdm_ff <= reg_wdata[4:0];                             // [RQ17]
  end

  // Only the warm flag reads back; everything else reads zero
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= rd_smr ? {warm_ff, 7'h00} : 8'h00;        // [RQ4]
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock gating and core outputs

  logic [3:0] div_ff;
  logic cpu_reset_ff;
  logic glob_ff;
  logic cpu_en_ff;
  logic timer_interrupt_clock_en_ff;
  logic osc_ff;
  logic restart_ff;
  logic flag_we_ff;

  wire slow_ok = ~smr_ff[SMR_DIV16] | (div_ff == DIV16_LAST); // [RQ9]

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_ff <= 4'h0;
      cpu_reset_ff <= 1'b1;
      glob_ff <= 1'b1;
      cpu_en_ff <= 1'b0;
      timer_interrupt_clock_en_ff <= 1'b0;
      osc_ff <= 1'b1;
      restart_ff <= 1'b0;
      flag_we_ff <= 1'b0;
    end
    else
    begin
      div_ff <= div_ff + 4'h1;
      cpu_reset_ff <= (nxt_state == ST_POR);                // [RQ2]
      glob_ff <= low_supply;                                // [RQ22]
      cpu_en_ff <= (nxt_state == ST_RUN) & slow_ok;         // [RQ3]
      timer_interrupt_clock_en_ff <= ((nxt_state == ST_RUN) |
                     (nxt_state == ST_HALT)) & slow_ok;     // [RQ3]
      osc_ff <= (nxt_state != ST_STOP);                     // [RQ7]
      restart_ff <= restart;
      flag_we_ff <= wdt_kick;                               // [RQ15]
    end
  end

  assign reg_rdata = rdata_ff;
  assign cpu_reset = cpu_reset_ff;
  assign global_reset = glob_ff;
  assign cpu_clk_en = cpu_en_ff;
  assign timer_interrupt_clk_en = timer_interrupt_clock_en_ff;
  assign xtal_osc_en = osc_ff;
  assign restart_req = restart_ff;
  assign restart_pc = RESTART_PC;                           // [RQ7]
  assign flag_we = flag_we_ff;
  assign flag_zsv = WDT_FLAG_ZSV;

endmodule

/* shw_ctl_props.sv */
/*
  Port checks for the reset, sleep and watchdog controller.
  Assumes one core clock domain and rstn active low.
*/
`timescale 1ns/10ps
module shw_ctl_props #(
  parameter int POR_CYC = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic reg_bank_f,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Events
  input wire logic insn_watchdog,
  input wire logic irq_wake,
  input wire logic supply_low,
  // Core control
  input wire logic cpu_reset,
  input wire logic global_reset,
  input wire logic cpu_clk_en,
  input wire logic timer_interrupt_clk_en,
  input wire logic xtal_osc_en,
  input wire logic restart_req,
  input wire logic [15:0] restart_pc,
  input wire logic flag_we,
  input wire logic [2:0] flag_zsv
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////
  // Cycles spent in reset hold, to bound the delay from below
  logic [23:0] hold_ff;
  logic [23:0] nxt_hold;
  assign nxt_hold = cpu_reset ? hold_ff + 24'h000001 : 24'h000000;
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      hold_ff <= 24'h000000;
    else
      hold_ff <= nxt_hold;

  ////////////////////////////////////////////////////////////////////////
  sequence s_rd(a);
    reg_bank_f && reg_rd && reg_addr == a;
  endsequence
  sequence s_halt;
    !cpu_clk_en && timer_interrupt_clk_en && xtal_osc_en;
  endsequence

  property p_rd_stop;
    s_rd(4'hB) |=> reg_rdata[6:0] == 7'h00;
  endproperty
  a_rd_stop: assert property (p_rd_stop)
    else $error("recovery register read shows stray bits");
  property p_rd_wdm;
    s_rd(4'hF) |=> reg_rdata == 8'h00;
  endproperty
  a_rd_wdm: assert property (p_rd_wdm)
    else $error("watchdog mode register readable");
  property p_por;
    $fell(cpu_reset) |-> hold_ff >= 24'(POR_CYC);
  endproperty
  a_por: assert property (p_por)
    else $error("reset hold too short");
  property p_halt;
    s_halt ##0 irq_wake |-> ##[1:16] cpu_clk_en;
  endproperty
  a_halt: assert property (p_halt)
    else $error("interrupt did not end halt");
  property p_stop;
    !xtal_osc_en |-> !cpu_clk_en && !timer_interrupt_clk_en;
  endproperty
  a_stop: assert property (p_stop)
    else $error("clock running with oscillator off");
  property p_pc;
    restart_req |-> restart_pc == 16'h000C ##1 !restart_req;
  endproperty
  a_pc: assert property (p_pc)
    else $error("bad restart request");
  property p_flag;
    flag_we |-> $past(insn_watchdog) && flag_zsv == 3'h0;
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag write without watchdog instruction");
  property p_low;
    supply_low [*3] |=> global_reset;
  endproperty
  a_low: assert property (p_low)
    else $error("low supply without global reset");
endmodule

bind shw_ctl shw_ctl_props #(.POR_CYC(POR_CYC)) u_props (
  .core_clk, .rstn, .reg_bank_f, .reg_addr, .reg_rd, .reg_rdata,
  .insn_watchdog, .irq_wake, .supply_low, .cpu_reset, .global_reset,
  .cpu_clk_en, .timer_interrupt_clk_en, .xtal_osc_en, .restart_req,
  .restart_pc, .flag_we, .flag_zsv
);

/* shw_core_model.sv */
/*
  Processor core stand-in: instruction events and interrupt wake.
  Assumes tasks are called just after a core clock edge.
*/
`timescale 1ns/10ps
module shw_core_model (
  // Clock
  input wire logic core_clk,
  // Instruction events
  output logic insn_stop,
  output logic insn_halt,
  output logic insn_watchdog,
  // Interrupt
  output logic irq_wake
);
  initial
  begin
    {insn_stop, insn_halt, insn_watchdog, irq_wake} = 4'h0;
  end

  // 0 stop, 1 halt, 2 watchdog; a no-op slot always goes first
  task automatic exec(input int op);
    @(posedge core_clk);
    #1;
    insn_stop = (op == 0);
    insn_halt = (op == 1);
    insn_watchdog = (op == 2);
    @(posedge core_clk);
    #1;
    {insn_stop, insn_halt, insn_watchdog} = 3'h0;
  endtask

  task automatic irq(input logic v);
    irq_wake = v;
  endtask
endmodule

/* stop_halt_watchdog_reset_ctl_bench.sv */
/*
  Self-checking bench for the reset, sleep and watchdog controller.
  Assumes short counts: reset hold 20 cycles, watchdog taps 16..256.
*/
`timescale 1ns/10ps
module stop_halt_watchdog_reset_ctl_bench
  import shw_pkg::*;
;
  localparam int POR = 20;
  logic core_clk, rstn, reg_bank_f, reg_wr, reg_rd;
  logic power_good, brownout_trip, supply_low, port3_analog;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, port2_in;
  logic [2:0] p3, zsv;
  logic insn_stop, insn_halt, insn_watchdog, irq_wake;
  logic cpu_reset, global_reset, cpu_clk_en, timer_interrupt_clock_en, xtal_osc_en;
  logic restart_req, flag_we, xtal;
  logic [15:0] restart_pc;
  logic [10:0] wk [7] = '{11'h17F, 11'h27F, 11'h47F, 11'h0FF,
                          11'h0F0, 11'h000, 11'h07F};
  int mismatches = 0;
  int checks_done = 0;
  int n;

  shw_ctl #(.POR_CYC(POR), .WDT_RC_0(16), .WDT_RC_1(32),
            .WDT_RC_2(64), .WDT_RC_3(256)) DUT (
    .core_clk, .rstn, .reg_bank_f, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .insn_stop, .insn_halt, .insn_watchdog,
    .irq_wake, .power_good, .brownout_trip, .supply_low,
    .crystal_input_pin(xtal), .port3_line1(p3[0]), .port3_line2(p3[1]),
    .port3_line3(p3[2]), .port2_in, .port3_analog, .cpu_reset,
    .global_reset, .cpu_clk_en, .timer_interrupt_clk_en(timer_interrupt_clock_en),
    .xtal_osc_en, .restart_req, .restart_pc, .flag_we, .flag_zsv(zsv)
  );
  shw_core_model core (
    .core_clk, .insn_stop, .insn_halt, .insn_watchdog, .irq_wake
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ok(input logic c);
    check({15'h0000, c}, 16'h0001);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    {reg_bank_f, reg_addr, reg_wdata, reg_wr} = {1'b1, a, d, 1'b1};
    step(1);
    {reg_bank_f, reg_wr} = 2'b00;
    // Idle edge so a following access never re-raises a strobe at once
    step(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    {reg_bank_f, reg_addr, reg_rd} = {1'b1, a, 1'b1};
    step(1);
    {reg_bank_f, reg_rd} = 2'b00;
    check({8'h00, reg_rdata}, {8'h00, e});
    step(1);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return cpu_reset;
      1: return restart_req;
      2: return cpu_clk_en;
      default: return global_reset;
    endcase
  endfunction
  // Bounded wait; the count tells callers how long it took
  task automatic wait_sig(input int s, input logic v, output int k);
    k = 0;
    while (sig(s) !== v && k < 3000)
    begin
      step(1);
      k++;
    end
    if (k >= 3000)
      mismatches++;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Crystal pin: one rising edge every 4 core cycles
  initial
  begin
    xtal = 1'b0;
    forever
    begin
      repeat (2) @(posedge core_clk);
      #1 xtal = ~xtal;
    end
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  initial
  begin
    {rstn, reg_bank_f, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {power_good, brownout_trip, supply_low, port3_analog} = 4'b1000;
    {p3, port2_in} = 11'h07F;
    step(8);
    rstn = 1'b1;
    wait_sig(0, 1'b0, n);
    ok(n >= POR && cpu_clk_en === 1'b1);
    rd(4'hB, 8'h00);
    rd(4'hF, 8'h00);
    rd(4'h5, 8'h00);
    wr(4'hF, 8'hE0);
    for (int i = 0; i < 7; i++)
    begin
      wr(4'hB, {1'b0, i != 6, i == 5, 3'(i % 6 + 2), 2'b00});
      {p3, port2_in} = (i == 6) ? 11'h17F : 11'h07F;
      core.exec(0);
      step(3);
      ok(xtal_osc_en === 1'b0 && cpu_clk_en === 1'b0);
      if (i == 0)
      begin
        port3_analog = 1'b1;
        {p3, port2_in} = wk[i];
        step(8);
        ok(xtal_osc_en === 1'b0);
        port3_analog = 1'b0;
      end
      {p3, port2_in} = wk[i];
      wait_sig(1, 1'b1, n);
      ok(i == 5 ? n >= POR : n <= 5);
      check(restart_pc, RESTART_PC);
    end
    rd(4'hB, 8'h80);
    core.exec(1);
    step(2);
    ok(!cpu_clk_en && timer_interrupt_clock_en && xtal_osc_en);
    core.irq(1'b1);
    wait_sig(2, 1'b1, n);
    ok(n <= 2);
    core.irq(1'b0);
    wr(4'hB, 8'h01);
    n = 0;
    repeat (64)
    begin
      step(1);
      n += int'(cpu_clk_en);
    end
    check(16'(n), 16'h0004);
    wr(4'hB, 8'h00);
    step(140);
    wr(4'hF, 8'h03);
    core.exec(2);
    ok(flag_we === 1'b1);
    check({13'h0000, zsv}, {13'h0000, WDT_FLAG_ZSV});
    repeat (3)
    begin
      step(8);
      core.exec(2);
    end
    ok(cpu_reset === 1'b0);
    wait_sig(0, 1'b1, n);
    ok(n >= 12 && n <= 22);
    wait_sig(0, 1'b0, n);
    rd(4'hB, 8'h00);
    core.exec(2);
    wait_sig(0, 1'b1, n);
    ok(n >= 28 && n <= 38);
    wait_sig(0, 1'b0, n);
    for (int k = 0; k < 2; k++)
    begin
      {supply_low, brownout_trip} = k ? 2'b10 : 2'b01;
      wait_sig(3, 1'b1, n);
      ok(n <= 4 && cpu_reset === 1'b1);
      {supply_low, brownout_trip} = 2'b00;
      wait_sig(0, 1'b0, n);
    end
    power_good = 1'b0;
    step(4);
    power_good = 1'b1;
    wait_sig(0, 1'b1, n);
    ok(n <= 5);
    wait_sig(0, 1'b0, n);
    ok(n >= POR);
    // Crystal-clocked recovery and watchdog, inside the fresh write window
    wr(4'hF, 8'h10);
    wr(4'hB, 8'h68);
    core.exec(0);
    {p3, port2_in} = 11'h17F;
    wait_sig(1, 1'b1, n);
    ok(n >= 1024 && n <= 1030);
    core.exec(2);
    wait_sig(0, 1'b1, n);
    ok(n >= 2040 && n <= 2052);
    close_out();
  end
endmodule
